// [iwa_pkg.sv]
// Constants shared by the relay word image block
package iwa_pkg;

    // ==========================================================
    // Area geometry
    localparam int          AREA_WORDS     = 236;
    localparam logic [7:0]  AREA_LAST      = 8'hEB;
    localparam int          WORD_BITS      = 16;
    localparam int          BLOCK_WORDS    = 10;

    // ==========================================================
    // Rack slot words
    localparam int          RACKS          = 3;
    localparam int          RACK_SLOTS     = 10;
    localparam int          RACK_BASE      = 0;

    // ==========================================================
    // Remote slave racks
    localparam int          SLAVE_UNITS    = 5;
    localparam int          SLAVE_BASE     = 50;

    // ==========================================================
    // Special units
    localparam int          SPECIAL_UNITS  = 10;
    localparam int          SPECIAL_BASE   = 100;

    // ==========================================================
    // Optical units
    localparam int          OPTICAL_UNITS  = 32;
    localparam int          OPTICAL_BASE   = 200;

    // ==========================================================
    // Word kinds
    localparam logic [1:0]  KIND_WORK      = 2'h0;
    localparam logic [1:0]  KIND_INPUT     = 2'h1;
    localparam logic [1:0]  KIND_OUTPUT    = 2'h2;
    localparam logic [1:0]  KIND_OUT_FLAG  = 2'h3;

    // ==========================================================
    // Field masks and digit coding
    localparam logic [15:0] MASK_ALL       = 16'hFFFF;
    localparam logic [15:0] MASK_NONE      = 16'h0000;
    localparam logic [15:0] MASK_LOW_BYTE  = 16'h00FF;
    localparam logic [15:0] MASK_FLAG_BYTE = 16'hFF00;
    localparam logic [3:0]  BCD_MAX        = 4'h9;
    localparam logic [15:0] RESET_WORD     = 16'h0000;

endpackage

// [iwa_bcd_check.sv]
// Decimal digit check and integer value of one word
module iwa_bcd_check
    import iwa_pkg::*;
#(
    parameter int DIGITS = 4
) (
    // Word under test
    input  wire logic [4*DIGITS-1:0] word_in,
    // Results
    output logic      [DIGITS-1:0]   digit_err_out,
    output logic      [4*DIGITS-1:0] value_out
);

    // ==========================================================
    // Per digit range check
    logic [4*DIGITS-1:0] part [0:DIGITS];

    assign part[DIGITS] = '0;

    for (genvar g = 0; g < DIGITS; g++) begin : g_digit
        assign digit_err_out[g] = word_in[4*g +: 4] > BCD_MAX;
        // Integer only: timer values stay counts of tenths
        assign part[g] = (4*DIGITS)'(part[g+1] * 10 + word_in[4*g +: 4]);
    end

    assign value_out = part[0];

endmodule

// [iwa_image.sv]
// Relay word image with I/O word allocation and scan refresh
module iwa_image
    import iwa_pkg::*;
(
    // Clock and reset
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    // Operation control
    input  wire logic                          stop_in,
    input  wire logic                          scan_end_in,
    // Allocation setup
    input  wire logic [2*RACKS*RACK_SLOTS-1:0] slot_kind_in,
    input  wire logic [2*SLAVE_UNITS-1:0]      slave_kind_in,
    input  wire logic [SLAVE_UNITS-1:0]        slave_wide_in,
    input  wire logic [2*SPECIAL_UNITS-1:0]    special_kind_in,
    input  wire logic [2*OPTICAL_UNITS-1:0]    optical_kind_in,
    // Program access
    input  wire logic                          prog_wr_in,
    input  wire logic                          prog_rd_in,
    input  wire logic                          prog_bit_mode_in,
    input  wire logic [7:0]                    prog_addr_in,
    input  wire logic [3:0]                    prog_bit_in,
    input  wire logic [15:0]                   prog_wdata_in,
    output logic      [15:0]                   prog_rdata_out,
    output logic                               prog_rvalid_out,
    output logic      [3:0]                    prog_digit_err_out,
    output logic      [15:0]                   prog_dec_value_out,
    output logic                               prog_err_out,
    // Field unit transfer
    output logic                               fio_req_out,
    output logic                               fio_we_out,
    output logic      [7:0]                    fio_addr_out,
    output logic      [15:0]                   fio_wdata_out,
    input  wire logic [15:0]                   fio_rdata_in,
    input  wire logic                          fio_ack_in,
    // Status
    output logic                               refresh_busy_out,
    output logic                               refresh_done_out,
    output logic                               cfg_err_out
);

    // ==========================================================
    // Storage and allocation table
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_WRITE,
        ST_READ
    } iwa_state_e;

    logic [15:0]  mem_q  [0:AREA_WORDS-1];
    logic [1:0]   kind_q [0:AREA_WORDS-1];
    iwa_state_e   state_q;
    logic [7:0]   walk_q;
    logic [1:0]   walk_kind;
    logic         walk_last;
    logic         cap_en;
    logic         addr_ok;
    logic [1:0]   prog_kind;
    logic [15:0]  prog_mask;
    logic [15:0]  prog_sel;
    logic [15:0]  rd_word;
    logic [3:0]   digit_err;
    logic [15:0]  dec_value;

    // Kind of a word from the setup vectors
    function automatic logic [1:0] kind_of(
        input int                              w,
        input logic [2*RACKS*RACK_SLOTS-1:0]   slots,
        input logic [2*SLAVE_UNITS-1:0]        slaves,
        input logic [SLAVE_UNITS-1:0]          wide,
        input logic [2*SPECIAL_UNITS-1:0]      specials,
        input logic [2*OPTICAL_UNITS-1:0]      opticals
    );
        logic [1:0] k;
        k = KIND_WORK;
        if (w >= RACK_BASE && w < RACK_BASE + RACKS * RACK_SLOTS) begin
            k = slots[2*(w-RACK_BASE) +: 2];
        end
        for (int u = 0; u < SLAVE_UNITS; u++) begin
            if (w >= SLAVE_BASE + BLOCK_WORDS * u &&
                w <  SLAVE_BASE + BLOCK_WORDS * (u + 1)) begin
                k = slaves[2*u +: 2];
                // A wide rack below owns this block as its second half
                if (u > 0 && wide[u-1]) begin
                    k = slaves[2*(u-1) +: 2];
                end
            end
        end
        for (int u = 0; u < SPECIAL_UNITS; u++) begin
            if (w >= SPECIAL_BASE + BLOCK_WORDS * u &&
                w <  SPECIAL_BASE + BLOCK_WORDS * (u + 1)) begin
                k = specials[2*u +: 2];
            end
        end
        if (w >= OPTICAL_BASE && w < OPTICAL_BASE + OPTICAL_UNITS) begin
            k = opticals[2*(w-OPTICAL_BASE) +: 2];
        end
        return k;
    endfunction

    // Table is registered so the long compare chains stay off the access path
    for (genvar w = 0; w < AREA_WORDS; w++) begin : g_kind
        always_ff @(posedge clk_in or posedge rst_in) begin
            if (rst_in) begin
                kind_q[w] <= KIND_WORK;
            end else begin
                kind_q[w] <= kind_of(w, slot_kind_in, slave_kind_in, slave_wide_in,
                                     special_kind_in, optical_kind_in);
            end
        end
    end

    // Top unit has no block above it for a second half
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_err_out <= 1'b0;
        end else begin
            cfg_err_out <= slave_wide_in[SLAVE_UNITS-1];
        end
    end

    // ==========================================================
    // Program write mask
    assign addr_ok   = prog_addr_in <= AREA_LAST;
    assign prog_kind = addr_ok ? kind_q[prog_addr_in] : KIND_WORK;
    assign prog_sel  = prog_bit_mode_in ? (16'h0001 << prog_bit_in) : MASK_ALL;

    always_comb begin
        case (prog_kind)
            KIND_INPUT:    prog_mask = MASK_NONE;
            KIND_OUT_FLAG: prog_mask = MASK_LOW_BYTE;
            default:       prog_mask = MASK_ALL;
        endcase
    end

    assign cap_en = (state_q == ST_READ) && fio_ack_in;

    // ==========================================================
    // Image storage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < AREA_WORDS; i++) begin
                mem_q[i] <= RESET_WORD;
            end
        end else if (stop_in) begin
            for (int i = 0; i < AREA_WORDS; i++) begin
                if (kind_q[i] == KIND_WORK) begin
                    mem_q[i] <= RESET_WORD;
                end else if (kind_q[i] == KIND_OUTPUT) begin
                    mem_q[i] <= RESET_WORD;
                end else if (kind_q[i] == KIND_OUT_FLAG) begin
                    mem_q[i] <= mem_q[i] & MASK_FLAG_BYTE;
                end
            end
        end else begin
            if (prog_wr_in && addr_ok) begin
                mem_q[prog_addr_in] <= (mem_q[prog_addr_in] & ~(prog_sel & prog_mask)) |
                                       (prog_wdata_in & prog_sel & prog_mask);
            end
            // Field data lands after the program write to the same word
            if (cap_en) begin
                if (walk_kind == KIND_OUT_FLAG) begin
                    mem_q[walk_q] <= (mem_q[walk_q] & MASK_LOW_BYTE) |
                                     (fio_rdata_in & MASK_FLAG_BYTE);
                end else begin
                    mem_q[walk_q] <= fio_rdata_in;
                end
            end
        end
    end

    // Flagged writes: out of range or touching field-owned bits (bits the word owns still land)
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prog_err_out <= 1'b0;
        end else begin
            prog_err_out <= prog_wr_in && (!addr_ok ||
                            ((prog_sel & ~prog_mask) != MASK_NONE));
        end
    end

    // ==========================================================
    // Program read port
    assign rd_word = addr_ok ? mem_q[prog_addr_in] : RESET_WORD;

    iwa_bcd_check #(
        .DIGITS (4)
    ) u_bcd (
        .word_in       (rd_word),
        .digit_err_out (digit_err),
        .value_out     (dec_value)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prog_rdata_out     <= RESET_WORD;
            prog_rvalid_out    <= 1'b0;
            prog_digit_err_out <= 4'h0;
            prog_dec_value_out <= RESET_WORD;
        end else begin
            prog_rvalid_out <= prog_rd_in;
            if (prog_rd_in) begin
                if (prog_bit_mode_in) begin
                    prog_rdata_out <= {15'h0000, rd_word[prog_bit_in]};
                end else begin
                    prog_rdata_out <= rd_word;
                end
                prog_digit_err_out <= digit_err;
                prog_dec_value_out <= dec_value;
            end
        end
    end

    // ==========================================================
    // Scan refresh walk
    assign walk_kind = kind_q[walk_q];
    assign walk_last = walk_q == AREA_LAST;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q          <= ST_IDLE;
            walk_q           <= 8'h00;
            fio_req_out      <= 1'b0;
            fio_we_out       <= 1'b0;
            fio_addr_out     <= 8'h00;
            fio_wdata_out    <= RESET_WORD;
            refresh_busy_out <= 1'b0;
            refresh_done_out <= 1'b0;
        end else begin
            refresh_done_out <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (scan_end_in && !stop_in) begin
                        walk_q           <= 8'h00;
                        state_q          <= ST_CHECK;
                        refresh_busy_out <= 1'b1;
                    end
                end
                ST_CHECK: begin
                    fio_addr_out <= walk_q;
                    if (walk_kind == KIND_OUTPUT || walk_kind == KIND_OUT_FLAG) begin
                        // Output words hold the last program value; flag words also hold field data in the high byte, masked off here
                        fio_wdata_out <= mem_q[walk_q] &
                                         (walk_kind == KIND_OUT_FLAG ? MASK_LOW_BYTE
                                                                     : MASK_ALL);
                        fio_req_out   <= 1'b1;
                        fio_we_out    <= 1'b1;
                        state_q       <= ST_WRITE;
                    end else if (walk_kind == KIND_INPUT) begin
                        fio_req_out <= 1'b1;
                        fio_we_out  <= 1'b0;
                        state_q     <= ST_READ;
                    end else if (walk_last) begin
                        state_q          <= ST_IDLE;
                        refresh_busy_out <= 1'b0;
                        refresh_done_out <= 1'b1;
                    end else begin
                        walk_q <= walk_q + 8'h01;
                    end
                end
                ST_WRITE: begin
                    if (fio_ack_in) begin
                        if (walk_kind == KIND_OUT_FLAG) begin
                            fio_we_out <= 1'b0;
                            state_q    <= ST_READ;
                        end else begin
                            fio_req_out <= 1'b0;
                            fio_we_out  <= 1'b0;
                            if (walk_last) begin
                                state_q          <= ST_IDLE;
                                refresh_busy_out <= 1'b0;
                                refresh_done_out <= 1'b1;
                            end else begin
                                walk_q  <= walk_q + 8'h01;
                                state_q <= ST_CHECK;
                            end
                        end
                    end
                end
                ST_READ: begin
                    if (fio_ack_in) begin
                        fio_req_out <= 1'b0;
                        if (walk_last) begin
                            state_q          <= ST_IDLE;
                            refresh_busy_out <= 1'b0;
                            refresh_done_out <= 1'b1;
                        end else begin
                            walk_q  <= walk_q + 8'h01;
                            state_q <= ST_CHECK;
                        end
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            // Stopping abandons the walk; outputs are not refreshed while stopped
            if (stop_in) begin
                state_q          <= ST_IDLE;
                fio_req_out      <= 1'b0;
                fio_we_out       <= 1'b0;
                refresh_busy_out <= 1'b0;
            end
        end
    end

endmodule

// [iwa_image_properties.sv]
// Port-level assertions for the relay word image block
module iwa_image_properties
    import iwa_pkg::*;
(
    // Clock and reset
    input wire logic                   clk_in,
    input wire logic                   rst_in,
    // Control and setup
    input wire logic                   stop_in,
    input wire logic                   scan_end_in,
    input wire logic [SLAVE_UNITS-1:0] slave_wide_in,
    // Program access
    input wire logic                   prog_wr_in,
    input wire logic                   prog_rd_in,
    input wire logic                   prog_bit_mode_in,
    input wire logic [7:0]             prog_addr_in,
    input wire logic [15:0]            prog_rdata_out,
    input wire logic                   prog_rvalid_out,
    input wire logic [3:0]             prog_digit_err_out,
    input wire logic                   prog_err_out,
    // Field transfer and status
    input wire logic                   fio_req_out,
    input wire logic                   fio_we_out,
    input wire logic [7:0]             fio_addr_out,
    input wire logic                   fio_ack_in,
    input wire logic                   refresh_busy_out,
    input wire logic                   refresh_done_out,
    input wire logic                   cfg_err_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    read_answer_a: assert property (prog_rd_in |=> prog_rvalid_out)
        else $error("read not answered one cycle later");
    answer_cause_a: assert property (prog_rvalid_out |-> $past(prog_rd_in))
        else $error("read answer without a read");
    range_refuse_a: assert property (
        prog_wr_in && !stop_in && prog_addr_in > AREA_LAST |=> prog_err_out)
        else $error("write beyond area not refused");
    digit_flag_a: assert property (prog_rvalid_out && !$past(prog_bit_mode_in) |->
        prog_digit_err_out == {prog_rdata_out[15:12] > BCD_MAX, prog_rdata_out[11:8] > BCD_MAX,
                               prog_rdata_out[7:4] > BCD_MAX, prog_rdata_out[3:0] > BCD_MAX})
        else $error("digit flags disagree with read word");
    req_hold_a: assert property (fio_req_out && !fio_ack_in && !stop_in |=>
        fio_req_out && $stable(fio_addr_out) && $stable(fio_we_out))
        else $error("field request changed before ack");
    scan_start_a: assert property (
        scan_end_in && !refresh_busy_out && !stop_in |=> refresh_busy_out)
        else $error("scan end did not start refresh");
    done_end_a: assert property (
        refresh_done_out |-> !refresh_busy_out && $past(refresh_busy_out))
        else $error("done pulse not at walk end");
    idle_quiet_a: assert property (!refresh_busy_out |-> !fio_req_out)
        else $error("field request outside refresh");
    stop_abort_a: assert property (stop_in |=> !fio_req_out)
        else $error("stop did not drop field request");
    wide_top_a: assert property (slave_wide_in[4] [*3] |-> cfg_err_out)
        else $error("wide slave at top unit not flagged");
endmodule

bind iwa_image iwa_image_properties chk (.clk_in(clk_in), .rst_in(rst_in), .stop_in(stop_in),
    .scan_end_in(scan_end_in), .slave_wide_in(slave_wide_in), .prog_wr_in(prog_wr_in),
    .prog_rd_in(prog_rd_in), .prog_bit_mode_in(prog_bit_mode_in), .prog_addr_in(prog_addr_in),
    .prog_rdata_out(prog_rdata_out), .prog_rvalid_out(prog_rvalid_out),
    .prog_digit_err_out(prog_digit_err_out), .prog_err_out(prog_err_out),
    .fio_req_out(fio_req_out), .fio_we_out(fio_we_out), .fio_addr_out(fio_addr_out),
    .fio_ack_in(fio_ack_in), .refresh_busy_out(refresh_busy_out),
    .refresh_done_out(refresh_done_out), .cfg_err_out(cfg_err_out));

// [iwa_field_model.sv]
// Field unit controller model answering refresh transfers
module iwa_field_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Answer delay in cycles
    input  wire logic [3:0]  delay_in,
    // Transfer
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    output logic      [15:0] rdata_out,
    output logic             ack_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] out_seen [256];
    logic        touched  [256];
    logic [3:0]  cnt_q;

    initial begin
        foreach (touched[i]) touched[i] = 1'b0;
    end

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
            cnt_q <= 4'h0;
            rdata_out <= 16'h0000;
        end else begin
            ack_out <= 1'b0;
            // Stale read data toggles so it never passes as valid
            rdata_out <= ~rdata_out;
            if (!req_in || ack_out) begin
                cnt_q <= 4'h0;
            end else if (cnt_q >= delay_in) begin
                ack_out <= 1'b1;
                touched[addr_in] <= 1'b1;
                if (we_in) out_seen[addr_in] <= wdata_in;
                else rdata_out <= {addr_in, ~addr_in};
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// [testbench.sv]
// Self-checking bench for the relay word image block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import iwa_pkg::*;

    logic        clk_in = 1'b0, rst_in = 1'b1, stop_in = 1'b0, scan_end_in = 1'b0;
    logic [59:0] slot_kind_in;
    logic [9:0]  slave_kind_in;
    logic [4:0]  slave_wide_in;
    logic [19:0] special_kind_in;
    logic [63:0] optical_kind_in;
    logic        prog_wr_in = 1'b0, prog_rd_in = 1'b0, prog_bit_mode_in = 1'b0;
    logic [7:0]  prog_addr_in = 8'h00;
    logic [3:0]  prog_bit_in = 4'h0, prog_digit_err_out, fm_delay = 4'h0;
    logic [15:0] prog_wdata_in = 16'h0000, prog_rdata_out, prog_dec_value_out, fio_wdata_out;
    logic [15:0] fio_rdata_in;
    logic [7:0]  fio_addr_out;
    logic        prog_rvalid_out, prog_err_out, fio_req_out, fio_we_out, fio_ack_in;
    logic        refresh_busy_out, refresh_done_out, cfg_err_out;
    int          failures = 0;
    int          num_checks = 0;

    iwa_image dut (.*);
    iwa_field_model fm (.clk_in(clk_in), .rst_in(rst_in), .delay_in(fm_delay),
        .req_in(fio_req_out), .we_in(fio_we_out), .addr_in(fio_addr_out),
        .wdata_in(fio_wdata_out), .rdata_out(fio_rdata_in), .ack_out(fio_ack_in));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic bm,
                      input logic [3:0] b, input logic err);
        @(posedge clk_in);
        prog_wr_in <= 1'b1;
        prog_addr_in <= a;
        prog_wdata_in <= d;
        prog_bit_mode_in <= bm;
        prog_bit_in <= b;
        @(posedge clk_in);
        prog_wr_in <= 1'b0;
        #1;
        check({15'h0000, prog_err_out}, {15'h0000, err});
    endtask

    task automatic rd(input logic [7:0] a, input logic bm, input logic [3:0] b,
                      input logic [15:0] exp);
        @(posedge clk_in);
        prog_rd_in <= 1'b1;
        prog_addr_in <= a;
        prog_bit_mode_in <= bm;
        prog_bit_in <= b;
        @(posedge clk_in);
        prog_rd_in <= 1'b0;
        #1;
        check({15'h0000, prog_rvalid_out}, 16'h0001);
        check(prog_rdata_out, exp);
    endtask

    task automatic refresh(input logic [3:0] dly);
        int i;
        fm_delay <= dly;
        @(posedge clk_in);
        scan_end_in <= 1'b1;
        @(posedge clk_in);
        scan_end_in <= 1'b0;
        #1;
        check({15'h0000, refresh_busy_out}, 16'h0001);
        i = 0;
        while (refresh_done_out !== 1'b1 && i < 3000) begin
            @(posedge clk_in);
            #1;
            i++;
        end
        check({15'h0000, refresh_done_out}, 16'h0001);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_digits();
        wr(8'h28, 16'h9A09, 1'b0, 4'h0, 1'b0);
        rd(8'h28, 1'b0, 4'h0, 16'h9A09);
        check({12'h000, prog_digit_err_out}, 16'h0004);
        wr(8'h29, 16'h1234, 1'b0, 4'h0, 1'b0);
        rd(8'h29, 1'b0, 4'h0, 16'h1234);
        check(prog_dec_value_out, 16'h04D2);
    endtask

    task automatic t_area();
        wr(8'hEB, 16'h8000, 1'b1, 4'hF, 1'b0);
        rd(8'hEB, 1'b0, 4'h0, 16'h8000);
        rd(8'hEB, 1'b1, 4'hF, 16'h0001);
        wr(8'hEC, 16'hFFFF, 1'b0, 4'h0, 1'b1);
        rd(8'hEC, 1'b0, 4'h0, 16'h0000);
    endtask

    task automatic t_guard();
        wr(8'h01, 16'hFFFF, 1'b0, 4'h0, 1'b1);
        rd(8'h01, 1'b0, 4'h0, 16'h0000);
        wr(8'h02, 16'hFFFF, 1'b0, 4'h0, 1'b1);
        rd(8'h02, 1'b0, 4'h0, 16'h00FF);
    endtask

    task automatic t_refresh();
        wr(8'h00, 16'h1111, 1'b0, 4'h0, 1'b0);
        wr(8'h00, 16'h2222, 1'b0, 4'h0, 1'b0);
        // Whole-word write covers the flag byte, so it is flagged though its low byte lands
        wr(8'h02, 16'h005A, 1'b0, 4'h0, 1'b1);
        wr(8'h0F, 16'h0F0F, 1'b0, 4'h0, 1'b0);
        wr(8'h37, 16'h5555, 1'b0, 4'h0, 1'b0);
        wr(8'hE7, 16'hBEEF, 1'b0, 4'h0, 1'b0);
        refresh(4'h0);
        check(fm.out_seen[0], 16'h2222);
        check(fm.out_seen[2], 16'h005A);
        check(fm.out_seen[15], 16'h0F0F);
        check(fm.out_seen[55], 16'h5555);
        check(fm.out_seen[231], 16'hBEEF);
        check({15'h0000, fm.touched[3] | fm.touched[30]}, 16'h0000);
        rd(8'h01, 1'b0, 4'h0, 16'h01FE);
        rd(8'h02, 1'b0, 4'h0, 16'h025A);
        rd(8'h55, 1'b0, 4'h0, 16'h55AA);
        rd(8'hC3, 1'b0, 4'h0, 16'hC33C);
    endtask

    task automatic t_stop();
        @(posedge clk_in);
        scan_end_in <= 1'b1;
        @(posedge clk_in);
        scan_end_in <= 1'b0;
        stop_in <= 1'b1;
        @(posedge clk_in);
        stop_in <= 1'b0;
        #1;
        check({15'h0000, refresh_busy_out}, 16'h0000);
        check({15'h0000, fio_req_out}, 16'h0000);
        rd(8'h29, 1'b0, 4'h0, 16'h0000);
        rd(8'h01, 1'b0, 4'h0, 16'h01FE);
        wr(8'h37, 16'h0A0A, 1'b0, 4'h0, 1'b0);
        refresh(4'h3);
        check(fm.out_seen[55], 16'h0A0A);
    endtask

    task automatic t_cfg();
        @(posedge clk_in);
        slave_wide_in[4] <= 1'b1;
        repeat (3) @(posedge clk_in);
        slave_wide_in[4] <= 1'b0;
        #1;
        check({15'h0000, cfg_err_out}, 16'h0001);
        @(posedge clk_in);
        #1;
        check({15'h0000, cfg_err_out}, 16'h0000);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        slot_kind_in = '0;
        slot_kind_in[1:0] = KIND_OUTPUT;
        slot_kind_in[3:2] = KIND_INPUT;
        slot_kind_in[5:4] = KIND_OUT_FLAG;
        slot_kind_in[31:30] = KIND_OUTPUT;
        slave_kind_in = {6'h00, KIND_INPUT, 2'h0, KIND_OUTPUT};
        slave_wide_in = 5'h04;
        special_kind_in = {KIND_INPUT, 18'h00000};
        optical_kind_in = {KIND_OUTPUT, 62'h0};
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        t_digits();
        t_area();
        t_guard();
        t_refresh();
        t_stop();
        t_cfg();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        close_out();
    end
endmodule
